// ===== hdl/rxad_regs.svh
`ifndef RXAD_REGS_SVH
`define RXAD_REGS_SVH

// Byte offsets on the register bus
`define RXAD_OFS_CONFIG 8'h00
`define RXAD_OFS_STATUS 8'h04
`define RXAD_OFS_ADJ_LO 8'h08
`define RXAD_OFS_ADJ_HI 8'h0c

// Configuration register fields
`define RXAD_DELAY_LSB 0
`define RXAD_DELAY_MSB 15
`define RXAD_MIN_DIAG_BIT 20
`define RXAD_RSVD_LSB 21
`define RXAD_RSVD_MSB 31

// Configuration register reset value; antenna delay field alone is 16'h4015
`define RXAD_CONFIG_RST 32'h0011_4015
`define RXAD_DELAY_RST 16'h4015
`define RXAD_MIN_DIAG_RST 1'b1

// Status register fields
`define RXAD_ST_DONE_BIT 0
`define RXAD_ST_FRDY_BIT 1
`define RXAD_ST_DVAL_BIT 2
`define RXAD_ST_BUSY_BIT 3

// Analyser processing time in clock cycles
`define RXAD_PROC_MIN_CYC 8
`define RXAD_PROC_FULL_CYC 24

// Antenna delay unit: one 499.2 MHz period divided by 128, in femtoseconds
`define RXAD_DELAY_LSB_FS 15650

`endif

// ===== hdl/rxad_pkg.sv
`default_nettype none
package rxad_pkg;
  typedef enum logic [1:0] {
    RXAD_IDLE,
    RXAD_BUSY
  } rxad_state_e;

  typedef struct packed {
    logic minimal_diagnostics;
    logic [15:0] rx_antenna_delay;
  } rxad_cfg_s;

  typedef struct packed {
    logic [39:0] raw_rx_timestamp;
    logic signed [15:0] first_path_corr;
  } rxad_rx_s;

  typedef logic [39:0] rxad_ts_t;
endpackage
`default_nettype wire

// ===== hdl/rxad_ts_adjust.sv
`default_nettype none
module rxad_ts_adjust
  import rxad_pkg::*;
#(
  parameter int TS_W = 40
) (
  input wire logic [TS_W-1:0] raw_ts,
  input wire logic [15:0] ant_delay,
  input wire logic signed [15:0] fp_corr,
  output logic [TS_W-1:0] adj_ts
);
  generate
    if (TS_W < 17) begin : g_bad_width
      $error("rxad_ts_adjust: TS_W must exceed the delay width");
    end
  endgenerate

  wire logic [TS_W-1:0] delay_ext;
  wire logic [TS_W-1:0] corr_ext;

  assign delay_ext = {{(TS_W-16){1'b0}}, ant_delay};
  // Sign extension keeps negative corrections moving the stamp later
  assign corr_ext = {{(TS_W-16){fp_corr[15]}}, fp_corr};
  assign adj_ts = raw_ts - delay_ext - corr_ext; // R4
endmodule
`default_nettype wire

// ===== hdl/rxad_config.sv
// Local design decision: the AHB-Lite interface to the registers.
`default_nettype none
`include "rxad_regs.svh"
// Notes on behaviour
// R1 - Bits 15..0 of the configuration register hold the receive antenna delay.
// R2 - Delay unit is one 499.2 MHz period over 128, about 15.65 ps.
// R3 - Antenna delay resets to 0x4015, about 256.74 ns.
// R4 - Adjusted stamp is raw stamp minus antenna delay minus first-path correction.
// R5 - Bit 20 is the minimal-diagnostics bit, reset to one.
// R6 - With minimal diagnostics off, analysis takes longer before done flags.
// R7 - With minimal diagnostics on, no diagnostic register updates happen.
// R8 - Software keeps reserved bits 31..21 at their reset values.
// R9 - Diagnostic results are valid only after analysis done for this reception.
// R10 - Reads return last written values; new values apply from next reception. A read whose address phase is a write's data phase gets the prior value.
module rxad_config
  import rxad_pkg::*;
#(
  parameter int TS_W = 40,
  parameter int PROC_MIN = `RXAD_PROC_MIN_CYC,
  parameter int PROC_FULL = `RXAD_PROC_FULL_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic RX_START,
  input wire logic [TS_W-1:0] RAW_RX_TIMESTAMP,
  input wire logic signed [15:0] FIRST_PATH_CORR,
  input wire logic PDOA_MODE3,
  output logic [TS_W-1:0] ADJ_RX_TIMESTAMP,
  output logic ANALYSIS_DONE_FLAG,
  output logic RX_FRAME_READY_FLAG,
  output logic DIAG_VALID,
  output logic PREAMBLE_DIAG_UPDATE,
  output logic SEQUENCE_DIAG_UPDATE,
  output logic SECOND_SEQUENCE_DIAG_UPDATE,
  output logic ANALYSER_BUSY
);
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] PROC_MIN_C = CNT_W'(PROC_MIN);
  localparam logic [CNT_W-1:0] PROC_FULL_C = CNT_W'(PROC_FULL);

  generate
    // Captured stamp is a 40-bit package field, so wider stamps cannot be served
    if (TS_W < 17 || TS_W > 40) begin : g_bad_ts
      $error("rxad_config: TS_W out of range");
    end
    if (PROC_MIN < 1 || PROC_FULL <= PROC_MIN || PROC_FULL > 255) begin : g_bad_proc
      $error("rxad_config: processing counts must satisfy 1 <= MIN < FULL <= 255");
    end
  endgenerate

  // Bus state
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;

  // Register state
  logic [31:0] config_r;
  logic done_r;
  logic frdy_r;
  logic dval_r;

  // Analyser state
  rxad_state_e state_r;
  rxad_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  rxad_cfg_s snap_r;
  rxad_rx_s rx_r;
  logic pdoa3_r;
  logic [TS_W-1:0] adj_r;
  logic pre_upd_r;
  logic seq_upd_r;
  logic seq2_upd_r;
  logic busy_r;

  wire logic addr_phase;
  wire logic rd_take;
  wire logic wr_take;
  wire logic word_size;
  wire logic [7:0] addr_lo;
  wire logic in_range;
  wire logic wr_config;
  wire logic wr_status;
  wire rxad_cfg_s cfg_now;
  wire logic start_take;
  wire logic finish;
  wire logic [TS_W-1:0] adj_calc;
  wire logic [63:0] adj_wide;
  wire logic clr_done;
  wire logic clr_frdy;

  assign addr_phase = HSEL & HTRANS[1] & HREADY;
  assign word_size = (HSIZE == 3'h2);
  assign addr_lo = HADDR[7:0];
  assign in_range = (HADDR[31:8] == 24'h00_0000);
  assign rd_take = addr_phase & ~HWRITE;
  // Narrow writes are dropped: every register is one whole word
  assign wr_take = addr_phase & HWRITE & word_size & in_range;
  assign wr_config = wr_pend_r & (wr_addr_r == `RXAD_OFS_CONFIG);
  assign wr_status = wr_pend_r & (wr_addr_r == `RXAD_OFS_STATUS);

  assign cfg_now.rx_antenna_delay = config_r[`RXAD_DELAY_MSB:`RXAD_DELAY_LSB]; // R1
  assign cfg_now.minimal_diagnostics = config_r[`RXAD_MIN_DIAG_BIT]; // R5

  // Read mux; reads are captured in the address phase for a zero-wait answer
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (!in_range) begin
      hrdata_nxt = 32'h0000_0000;
    end else if (addr_lo == `RXAD_OFS_CONFIG) begin
      hrdata_nxt = config_r; // R10
    end else if (addr_lo == `RXAD_OFS_STATUS) begin
      hrdata_nxt[`RXAD_ST_DONE_BIT] = done_r;
      hrdata_nxt[`RXAD_ST_FRDY_BIT] = frdy_r;
      hrdata_nxt[`RXAD_ST_DVAL_BIT] = dval_r;
      hrdata_nxt[`RXAD_ST_BUSY_BIT] = busy_r;
    end else if (addr_lo == `RXAD_OFS_ADJ_LO) begin
      hrdata_nxt = adj_wide[31:0];
    end else if (addr_lo == `RXAD_OFS_ADJ_HI) begin
      hrdata_nxt = adj_wide[63:32];
    end
  end

  assign adj_wide = {{(64-TS_W){1'b0}}, adj_r};

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= wr_take ? addr_lo : wr_addr_r;
      hreadyout_r <= 1'b1;
      hrdata_r <= rd_take ? hrdata_nxt : hrdata_r;
    end
  end

  // Reserved bits are stored as written; software is expected to leave them alone
  always_ff @(posedge MCLK) begin
    if (RST) begin
      config_r <= `RXAD_CONFIG_RST; // R3
    end else if (wr_config) begin
      config_r <= HWDATA; // R8
    end
  end

  // Analyser sequencing
  assign start_take = (state_r == RXAD_IDLE) & RX_START;
  assign finish = (state_r == RXAD_BUSY) & (cnt_r == 8'h01);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RXAD_IDLE: begin
        if (RX_START) begin
          state_nxt = RXAD_BUSY;
        end
      end
      RXAD_BUSY: begin
        if (cnt_r == 8'h01) begin
          state_nxt = RXAD_IDLE;
        end
      end
      default: begin
        state_nxt = RXAD_IDLE;
      end
    endcase
  end

  rxad_ts_adjust #(
    .TS_W(TS_W)
  ) u_adjust (
    .raw_ts(rx_r.raw_rx_timestamp[TS_W-1:0]),
    .ant_delay(snap_r.rx_antenna_delay), // R2
    .fp_corr(rx_r.first_path_corr),
    .adj_ts(adj_calc)
  );

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_r <= RXAD_IDLE;
      cnt_r <= 8'h00;
      snap_r <= '{minimal_diagnostics: `RXAD_MIN_DIAG_RST, rx_antenna_delay: `RXAD_DELAY_RST};
      rx_r <= '0;
      pdoa3_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt == RXAD_BUSY);
      if (start_take) begin
        // Snapshot so a mid-analysis write waits for the next reception
        snap_r <= cfg_now; // R10
        rx_r.raw_rx_timestamp <= 40'(RAW_RX_TIMESTAMP);
        rx_r.first_path_corr <= FIRST_PATH_CORR;
        pdoa3_r <= PDOA_MODE3;
        cnt_r <= cfg_now.minimal_diagnostics ? PROC_MIN_C : PROC_FULL_C; // R6
      end else if (state_r == RXAD_BUSY) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // Status: write one to clear, a same-cycle set wins
  assign clr_done = wr_status & HWDATA[`RXAD_ST_DONE_BIT];
  assign clr_frdy = wr_status & HWDATA[`RXAD_ST_FRDY_BIT];

  always_ff @(posedge MCLK) begin
    if (RST) begin
      done_r <= 1'b0;
      frdy_r <= 1'b0;
      dval_r <= 1'b0;
      adj_r <= '0;
      pre_upd_r <= 1'b0;
      seq_upd_r <= 1'b0;
      seq2_upd_r <= 1'b0;
    end else begin
      done_r <= finish | (done_r & ~clr_done & ~start_take);
      frdy_r <= finish | (frdy_r & ~clr_frdy & ~start_take);
      // Stale diagnostics are withdrawn as soon as a new reception starts
      dval_r <= (finish & ~snap_r.minimal_diagnostics) |
        (dval_r & ~clr_done & ~start_take); // R9
      adj_r <= finish ? adj_calc : adj_r; // R4
      pre_upd_r <= finish & ~snap_r.minimal_diagnostics; // R7
      seq_upd_r <= finish & ~snap_r.minimal_diagnostics; // R7
      seq2_upd_r <= finish & ~snap_r.minimal_diagnostics & pdoa3_r; // R7
    end
  end

  assign HREADYOUT = hreadyout_r;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_r;
  assign ADJ_RX_TIMESTAMP = adj_r;
  assign ANALYSIS_DONE_FLAG = done_r;
  assign RX_FRAME_READY_FLAG = frdy_r;
  assign DIAG_VALID = dval_r;
  assign PREAMBLE_DIAG_UPDATE = pre_upd_r;
  assign SEQUENCE_DIAG_UPDATE = seq_upd_r;
  assign SECOND_SEQUENCE_DIAG_UPDATE = seq2_upd_r;
  assign ANALYSER_BUSY = busy_r;
endmodule
`default_nettype wire

// ===== tb/rxad_config_properties.sv
`default_nettype none
module rxad_chk #(parameter int TS_W = 40, parameter int PROC_MIN = 8, parameter int PROC_FULL = 24) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic RX_START,
  input wire logic [TS_W-1:0] ADJ_RX_TIMESTAMP,
  input wire logic ANALYSIS_DONE_FLAG,
  input wire logic RX_FRAME_READY_FLAG,
  input wire logic DIAG_VALID,
  input wire logic PREAMBLE_DIAG_UPDATE,
  input wire logic SEQUENCE_DIAG_UPDATE,
  input wire logic SECOND_SEQUENCE_DIAG_UPDATE,
  input wire logic ANALYSER_BUSY
);
  logic [7:0] busy_cnt_r;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // Busy span length tells which processing time was used
  always_ff @(posedge MCLK) begin
    busy_cnt_r <= (RST || !ANALYSER_BUSY) ? 8'h00 : busy_cnt_r + 8'h01;
  end
  resp_okay_a: assert property (HRESP == 1'b0) else $error("bus response not okay");
  ready_after_rst_a: assert property (!$past(RST) |-> HREADYOUT)
    else $error("bus not ready after reset");
  proc_time_a: assert property ($fell(ANALYSER_BUSY) |->
    (busy_cnt_r == PROC_MIN || busy_cnt_r == PROC_FULL)) else $error("bad busy length");
  done_flags_a: assert property ($fell(ANALYSER_BUSY) |-> ANALYSIS_DONE_FLAG && RX_FRAME_READY_FLAG)
    else $error("done flags missing at finish");
  diag_gate_a: assert property (PREAMBLE_DIAG_UPDATE |-> ANALYSIS_DONE_FLAG && DIAG_VALID)
    else $error("diag update without valid done");
  diag_pulse_a: assert property (PREAMBLE_DIAG_UPDATE |=> !PREAMBLE_DIAG_UPDATE)
    else $error("diag update not a pulse");
  diag_pair_a: assert property (SEQUENCE_DIAG_UPDATE == PREAMBLE_DIAG_UPDATE &&
    (!SECOND_SEQUENCE_DIAG_UPDATE || SEQUENCE_DIAG_UPDATE)) else $error("diag updates disagree");
  adj_hold_a: assert property (ANALYSER_BUSY && $past(ANALYSER_BUSY) |-> $stable(ADJ_RX_TIMESTAMP))
    else $error("stamp moved while busy");
  start_clear_a: assert property (RX_START && !ANALYSER_BUSY |=> ANALYSER_BUSY &&
    !ANALYSIS_DONE_FLAG && !DIAG_VALID) else $error("start not taken");
  unmapped_zero_a: assert property (HSEL && HTRANS[1] && HREADY && !HWRITE && HADDR[31:8] != 0
    |=> HRDATA == 32'h0) else $error("unmapped read not zero");
  cover property (SECOND_SEQUENCE_DIAG_UPDATE);
  cover property ($fell(ANALYSER_BUSY) && !DIAG_VALID);
  cover property ($rose(ANALYSER_BUSY));
endmodule
bind rxad_config rxad_chk #(.TS_W(TS_W), .PROC_MIN(PROC_MIN), .PROC_FULL(PROC_FULL)) i_rxad_chk (
  .MCLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .HRDATA,
  .RX_START, .ADJ_RX_TIMESTAMP, .ANALYSIS_DONE_FLAG, .RX_FRAME_READY_FLAG, .DIAG_VALID,
  .PREAMBLE_DIAG_UPDATE, .SEQUENCE_DIAG_UPDATE, .SECOND_SEQUENCE_DIAG_UPDATE, .ANALYSER_BUSY);
`default_nettype wire

// ===== tb/rxad_config_test.sv
`default_nettype none
module rxad_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, RX_START, PDOA_MODE3;
  logic [31:0] HADDR, HWDATA, HRDATA, q;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [39:0] RAW_RX_TIMESTAMP, ADJ_RX_TIMESTAMP;
  logic signed [15:0] FIRST_PATH_CORR;
  logic done, frdy, dval, pre_up, seq_up, sec_up, busy;
  int err_total, checked, cyc;
  rxad_config i_rxad_config (.MCLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HREADYOUT, .HRESP, .HRDATA, .RX_START, .RAW_RX_TIMESTAMP,
    .FIRST_PATH_CORR, .PDOA_MODE3, .ADJ_RX_TIMESTAMP, .ANALYSIS_DONE_FLAG(done),
    .RX_FRAME_READY_FLAG(frdy), .DIAG_VALID(dval), .PREAMBLE_DIAG_UPDATE(pre_up),
    .SEQUENCE_DIAG_UPDATE(seq_up), .SECOND_SEQUENCE_DIAG_UPDATE(sec_up), .ANALYSER_BUSY(busy));
  always #2.5 MCLK = ~MCLK;
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(input logic [39:0] s, input logic [39:0] x);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Single AHB transfer; address phase held until ready, data phase likewise
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    HSIZE <= 3'h2;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk({8'h0, q}, {8'h0, x});
  endtask
  task automatic rx(input logic [39:0] raw, input logic [15:0] c, input logic m3, input int n,
    input logic dg, input logic [15:0] d);
    int k;
    logic [39:0] e;
    e = raw - {24'h0, d} - {{24{c[15]}}, c};
    RX_START <= 1'b1;
    RAW_RX_TIMESTAMP <= raw;
    FIRST_PATH_CORR <= c;
    PDOA_MODE3 <= m3;
    @(posedge MCLK);
    RX_START <= 1'b0;
    @(posedge MCLK);
    chk({39'h0, busy}, 40'h1);
    k = 1;
    while (done !== 1'b1 && k < 100) begin
      @(posedge MCLK);
      k++;
    end
    chk(40'(k), 40'(n + 1));
    chk({38'h0, frdy, busy}, {38'h0, 2'b10});
    chk(ADJ_RX_TIMESTAMP, e);
    chk({36'h0, pre_up, seq_up, sec_up, dval}, {36'h0, dg, dg, dg & m3, dg});
    $display("reception done, %0d cycles", k);
  endtask
  initial begin
    MCLK = 0;
    RST = 1;
    HSEL = 0;
    HADDR = 0;
    HTRANS = 0;
    HWRITE = 0;
    HSIZE = 3'h2;
    HWDATA = 0;
    RX_START = 0;
    RAW_RX_TIMESTAMP = 0;
    FIRST_PATH_CORR = 0;
    PDOA_MODE3 = 0;
    err_total = 0;
    checked = 0;
    cyc = 0;
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    rd(32'h0, 32'h0011_4015);
    chk({39'h0, HRESP}, 40'h0);
    xfer(1'b1, 32'h0, 32'h0001_1234);
    @(posedge MCLK);
    rd(32'h0, 32'h0001_1234);
    $display("config register test done");
    // Config rewritten mid-reception must not affect this one
    fork
      rx(40'h12_0000_0000, 16'hfffb, 1'b1, 24, 1'b1, 16'h1234);
      begin
        repeat (3) @(posedge MCLK);
        xfer(1'b1, 32'h0, 32'h0011_4015);
      end
    join
    rd(32'h4, 32'h7);
    rd(32'h8, 32'hffff_edd1);
    xfer(1'b1, 32'h8, 32'h5a5a_5a5a);
    @(posedge MCLK);
    rd(32'h8, 32'hffff_edd1);
    $display("full diagnostics test done");
    rx(40'h00_0000_1000, 16'h0010, 1'b1, 8, 1'b0, 16'h4015);
    rd(32'h4, 32'h3);
    xfer(1'b1, 32'h4, 32'h3);
    @(posedge MCLK);
    rd(32'h4, 32'h0);
    rd(32'h100, 32'h0);
    $display("minimal diagnostics test done");
    // Full diagnostics without phase-difference mode 3: no second-sequence update
    xfer(1'b1, 32'h0, 32'h0001_4015);
    @(posedge MCLK);
    rx(40'h00_0000_5000, 16'h0000, 1'b0, 24, 1'b1, 16'h4015);
    $display("single sequence test done");
    conclude();
  end
endmodule
`default_nettype wire
